// [hdl/gain_amp_map.svh]
/*
 * register map, field positions, reset values and bus codes of the gain
 * amplifier control block; assumes inclusion by every design file that
 * decodes or checks the control registers.
 */
`ifndef GAIN_AMP_MAP_SVH
`define GAIN_AMP_MAP_SVH

// register indexes as printed, byte address is four times the index
`define AMP_PRI_IDX 16'hffe1
`define AMP_SEC_IDX 16'hffe4
`define AMP_PRI_ADDR 18'h3_ff84
`define AMP_SEC_ADDR 18'h3_ff90
`define AMP_ADDR_BITS 18

// field positions
`define AMP_GAIN_LO 0
`define AMP_GAIN_HI 1
`define AMP_GROUND_BIT 4
`define AMP_CHAN_LO 5
`define AMP_CHAN_HI 6
`define AMP_ENABLE_BIT 7
`define AMP_AUX_BIT 0

// reset values and writable masks
`define AMP_REG_RESET 8'h00
`define AMP_PRI_WMASK 8'hf3
`define AMP_SEC_WMASK 8'h01

// gain factors per code
`define AMP_GAIN_X2 5'h02
`define AMP_GAIN_X4 5'h04
`define AMP_GAIN_X8 5'h08
`define AMP_GAIN_X16 5'h10

// bus answers
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

// [hdl/gain_amp_pkg.sv]
/*
 * types shared by the gain amplifier control files; assumes the map
 * header supplies all numeric constants.
 */
package gain_amp_pkg;
    typedef logic [7:0] amp_reg_t;
    typedef enum logic [1:0] {GAIN_X2, GAIN_X4, GAIN_X8, GAIN_X16} amp_gain_t;
    typedef enum logic [1:0] {CHAN_2B, CHAN_2A, CHAN_1B, CHAN_1A} amp_channel_t;
    typedef logic [3:0] amp_onehot_t;
    typedef logic [4:0] amp_factor_t;
endpackage

// [hdl/amp_gain_decode.sv]
/*
 * combinational decode of the gain selector into a gain factor and a
 * one-hot gain strobe; assumes the caller registers the results.
 */
`timescale 1ns/1ps
`include "gain_amp_map.svh"

module amp_gain_decode (
    // selector in
    input wire gain_amp_pkg::amp_gain_t gainSel,
    // decoded out
    output gain_amp_pkg::amp_factor_t gainFactor,
    output gain_amp_pkg::amp_onehot_t gainOneHot
);
    // every code is legal, so no default item
    always_comb begin
        gainOneHot = 4'h0;
        gainFactor = `AMP_GAIN_X2;
        unique case (gainSel)
            gain_amp_pkg::GAIN_X2: begin
                gainFactor = `AMP_GAIN_X2;
            end
            gain_amp_pkg::GAIN_X4: begin
                gainFactor = `AMP_GAIN_X4;
            end
            gain_amp_pkg::GAIN_X8: begin
                gainFactor = `AMP_GAIN_X8;
            end
            gain_amp_pkg::GAIN_X16: begin
                gainFactor = `AMP_GAIN_X16;
            end
        endcase
        gainOneHot[gainSel] = 1'b1;
    end
endmodule

// [hdl/amp_input_route.sv]
/*
 * combinational routing of the amplifier input: one-hot comparator input
 * select, all zero while the input is grounded; assumes caller registers.
 */
`timescale 1ns/1ps
`include "gain_amp_map.svh"

module amp_input_route (
    // control in
    input wire gain_amp_pkg::amp_channel_t chanSel,
    input wire logic ground,
    // route out, bit 0 = input 2B ... bit 3 = input 1A
    output gain_amp_pkg::amp_onehot_t routeOneHot
);
    // grounding wins so no comparator input is ever tied to a grounded node
    always_comb begin
        routeOneHot = 4'h0;
        if (!ground) begin
            routeOneHot[chanSel] = 1'b1;
        end
    end
endmodule

// [hdl/gain_amp_control_regs.sv]
/*
 * control registers of one programmable gain amplifier channel behind an
 * AXI4-Lite slave, with registered decoded controls for the analog side;
 * assumes one clock, asynchronous active high reset, 32-bit bus data.
 */
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "gain_amp_map.svh"

module gain_amp_control_regs #(
    parameter int ADDR_W = 18
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // write address channel
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // write data channel
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // write response channel
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read address channel
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // read data channel
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // amplifier controls
    output logic ampEnable,
    output logic ampInputGround,
    output gain_amp_pkg::amp_onehot_t ampChannelSel,
    output gain_amp_pkg::amp_factor_t ampGainFactor,
    output gain_amp_pkg::amp_onehot_t ampGainOneHot,
    output logic ampAuxControlBit
);
    // the register offsets need at least this many address bits; refused at elaboration
    if (ADDR_W < `AMP_ADDR_BITS || ADDR_W > 32) begin : g_badAddrW
        $error("gain_amp_control_regs: ADDR_W out of range");
    end

    gain_amp_pkg::amp_reg_t primaryCtl_ff;
    gain_amp_pkg::amp_reg_t secondaryCtl_ff;
    logic [ADDR_W-1:0] awAddr_ff;
    logic [7:0] wData_ff;
    logic wLane0_ff;
    logic awGot_ff;
    logic wGot_ff;
    logic awHs;
    logic wHs;
    logic arHs;
    logic doWrite;
    logic wrPri;
    logic wrSec;
    logic rdPri;
    logic rdSec;
    gain_amp_pkg::amp_factor_t decFactor;
    gain_amp_pkg::amp_onehot_t decGainOneHot;
    gain_amp_pkg::amp_onehot_t decRoute;

    // handshakes and address decode
    assign awHs = s_axi_awvalid & s_axi_awready;
    assign wHs = s_axi_wvalid & s_axi_wready;
    assign arHs = s_axi_arvalid & s_axi_arready;
    assign doWrite = awGot_ff & wGot_ff;
    assign wrPri = awAddr_ff == ADDR_W'(`AMP_PRI_ADDR);
    assign wrSec = awAddr_ff == ADDR_W'(`AMP_SEC_ADDR);
    assign rdPri = s_axi_araddr == ADDR_W'(`AMP_PRI_ADDR);
    assign rdSec = s_axi_araddr == ADDR_W'(`AMP_SEC_ADDR);

    // write address capture, taken independently of the data
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            awAddr_ff <= '0;
            awGot_ff <= 1'b0;
        end else if (awHs) begin
            awAddr_ff <= s_axi_awaddr;
            awGot_ff <= 1'b1;
        end else if (doWrite) begin
            awGot_ff <= 1'b0;
        end
    end

    // write data capture; only byte lane 0 carries register bits
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wData_ff <= 8'h00;
            wLane0_ff <= 1'b0;
            wGot_ff <= 1'b0;
        end else if (wHs) begin
            wData_ff <= s_axi_wdata[7:0];
            wLane0_ff <= s_axi_wstrb[0];
            wGot_ff <= 1'b1;
        end else if (doWrite) begin
            wGot_ff <= 1'b0;
        end
    end

    // ready flags drop on each handshake and return once the response is gone
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            if (awHs) begin
                s_axi_awready <= 1'b0;
            end else if (!awGot_ff && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            if (wHs) begin
                s_axi_wready <= 1'b0;
            end else if (!wGot_ff && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
        end
    end

    // write response, held until the master takes it
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `AXI_RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wrPri || wrSec) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // primary control; reserved bits 3:2 never take a write
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            primaryCtl_ff <= `AMP_REG_RESET;
        end else if (doWrite && wrPri && wLane0_ff) begin
            primaryCtl_ff <= wData_ff & `AMP_PRI_WMASK;
        end
    end

    // secondary control, only bit 0 is storage
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            secondaryCtl_ff <= `AMP_REG_RESET;
        end else if (doWrite && wrSec && wLane0_ff) begin
            secondaryCtl_ff <= wData_ff & `AMP_SEC_WMASK;
        end
    end

    // read address ready, one read under way at a time
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
        end else if (arHs) begin
            s_axi_arready <= 1'b0;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

    // read data; unmapped addresses answer zero with an error
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `AXI_RESP_OKAY;
        end else if (arHs) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= (rdPri || rdSec) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
            if (rdPri) begin
                s_axi_rdata <= {24'h00_0000, primaryCtl_ff & `AMP_PRI_WMASK};
            end else if (rdSec) begin
                s_axi_rdata <= {24'h00_0000, secondaryCtl_ff & `AMP_SEC_WMASK};
            end else begin
                s_axi_rdata <= 32'h0000_0000;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // field decoders
    amp_gain_decode u_gain (
        .gainSel(gain_amp_pkg::amp_gain_t'(primaryCtl_ff[`AMP_GAIN_HI:`AMP_GAIN_LO])),
        .gainFactor(decFactor),
        .gainOneHot(decGainOneHot)
    );

    amp_input_route u_route (
        .chanSel(gain_amp_pkg::amp_channel_t'(primaryCtl_ff[`AMP_CHAN_HI:`AMP_CHAN_LO])),
        .ground(primaryCtl_ff[`AMP_GROUND_BIT]),
        .routeOneHot(decRoute)
    );

    // analog controls registered so they settle glitch free, one cycle behind the register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ampEnable <= 1'b0;
            ampInputGround <= 1'b0;
            ampChannelSel <= 4'h1;
            ampGainFactor <= `AMP_GAIN_X2;
            ampGainOneHot <= 4'h1;
            ampAuxControlBit <= 1'b0;
        end else begin
            ampEnable <= primaryCtl_ff[`AMP_ENABLE_BIT];
            ampInputGround <= primaryCtl_ff[`AMP_GROUND_BIT];
            ampChannelSel <= decRoute;
            ampGainFactor <= decFactor;
            ampGainOneHot <= decGainOneHot;
            ampAuxControlBit <= secondaryCtl_ff[`AMP_AUX_BIT];
        end
    end

    // checks
    sequence s_wrAccepted;
        awGot_ff && wGot_ff;
    endsequence

    sequence s_respGiven;
        s_axi_bvalid ##0 $stable(s_axi_bresp);
    endsequence

    property p_gainFactor;
        @(posedge sys_clk) disable iff (rst)
        ##1 ampGainFactor == (5'h02 << $past(primaryCtl_ff[1:0], 1));
    endproperty
    a_gainFactor: assert property (p_gainFactor) else $error("gain factor does not follow selector");

    property p_gainLowest;
        @(posedge sys_clk) disable iff (rst)
        primaryCtl_ff[1:0] == 2'h0 |=> ampGainFactor == 5'h02 && ampGainOneHot == 4'h1;
    endproperty
    a_gainLowest: assert property (p_gainLowest) else $error("code zero not gain two");

    property p_ground;
        @(posedge sys_clk) disable iff (rst)
        primaryCtl_ff[4] |=> ampInputGround && ampChannelSel == 4'h0;
    endproperty
    a_ground: assert property (p_ground) else $error("grounded input still routed");

    property p_route;
        @(posedge sys_clk) disable iff (rst)
        !primaryCtl_ff[4] |=> !ampInputGround && ampChannelSel == (4'h1 << $past(primaryCtl_ff[6:5], 1));
    endproperty
    a_route: assert property (p_route) else $error("input route wrong");

    property p_enable;
        @(posedge sys_clk) disable iff (rst)
        1'b1 |=> ampEnable == $past(primaryCtl_ff[`AMP_ENABLE_BIT], 1);
    endproperty
    a_enable: assert property (p_enable) else $error("enable does not follow bit 7");

    property p_secUnused;
        @(posedge sys_clk) disable iff (rst)
        1'b1 |-> (secondaryCtl_ff & ~`AMP_SEC_WMASK) == `AMP_REG_RESET;
    endproperty
    a_secUnused: assert property (p_secUnused) else $error("secondary unused bits set");

    // aux control output trails the stored bit by one clock
    property p_auxFollow;
        @(posedge sys_clk) disable iff (rst)
        1'b1 |=> ampAuxControlBit == $past(secondaryCtl_ff[`AMP_AUX_BIT], 1);
    endproperty
    a_auxFollow: assert property (p_auxFollow) else $error("aux control does not follow bit 0");

    // one-hot gain strobe must agree with the selector code
    property p_gainOneHot;
        @(posedge sys_clk) disable iff (rst)
        1'b1 |=> ampGainOneHot == (4'h1 << $past(primaryCtl_ff[`AMP_GAIN_HI:`AMP_GAIN_LO], 1));
    endproperty
    a_gainOneHot: assert property (p_gainOneHot) else $error("gain strobe does not follow selector");

    property p_resetZero;
        @(posedge sys_clk)
        $fell(rst) |-> primaryCtl_ff == 8'h00 && secondaryCtl_ff == 8'h00 && !ampEnable && ampGainFactor == 5'h02;
    endproperty
    a_resetZero: assert property (p_resetZero) else $error("registers not zero after reset");

    property p_reservedZero;
        @(posedge sys_clk) disable iff (rst)
        (1'b1 |-> (primaryCtl_ff & ~`AMP_PRI_WMASK) == `AMP_REG_RESET)
            and (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000);
    endproperty
    a_reservedZero: assert property (p_reservedZero) else $error("reserved bits not zero");

    property p_writeResp;
        @(posedge sys_clk) disable iff (rst)
        s_wrAccepted |=> s_axi_bvalid;
    endproperty
    a_writeResp: assert property (p_writeResp) else $error("write response late");

    // read data answers the clock after the address is taken
    property p_readResp;
        @(posedge sys_clk) disable iff (rst)
        arHs |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h00_0000;
    endproperty
    a_readResp: assert property (p_readResp) else $error("read response late");

    property p_respHold;
        @(posedge sys_clk) disable iff (rst)
        s_axi_bvalid && !s_axi_bready |=> s_respGiven;
    endproperty
    a_respHold: assert property (p_respHold) else $error("write response dropped before taken");
endmodule

// [verification/tb.sv]
/*
 * self-checking bench of the gain amplifier control registers over AXI4-Lite;
 * assumes the map header, the package and the checks inside the design files.
 */
`timescale 1ns/1ps
`include "gain_amp_map.svh"

module tb;
    // clock, reset and bus signals
    logic sys_clk = 1'b0, rst = 1'b1;
    logic [17:0] awAddr = '0, arAddr = '0;
    logic [31:0] wData = '0, rData;
    logic [3:0] wStrb = '0;
    logic awValid = 0, awReady, wValid = 0, wReady, bValid, bReady = 0;
    logic arValid = 0, arReady, rValid, rReady = 0;
    logic [1:0] bResp, rResp;
    logic ampEnable, ampInputGround, ampAuxControlBit;
    gain_amp_pkg::amp_onehot_t ampChannelSel, ampGainOneHot;
    gain_amp_pkg::amp_factor_t ampGainFactor;
    int numErrors = 0, nChecks = 0;

    always #5 sys_clk = ~sys_clk;

    gain_amp_control_regs #(.ADDR_W(18)) dut_u (.sys_clk(sys_clk), .rst(rst),
        .s_axi_awaddr(awAddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .ampEnable(ampEnable), .ampInputGround(ampInputGround), .ampChannelSel(ampChannelSel),
        .ampGainFactor(ampGainFactor), .ampGainOneHot(ampGainOneHot), .ampAuxControlBit(ampAuxControlBit));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp) begin
            numErrors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // write: address and data offered together, each released once taken
    task automatic bus_write(input logic [17:0] a, input logic [31:0] d, input logic [3:0] s,
                             input logic [1:0] expResp);
        int n;
        logic awDone, wDone;
        awDone = 0;
        wDone = 0;
        n = 0;
        @(posedge sys_clk);
        awAddr <= a;
        wData <= d;
        wStrb <= s;
        awValid <= 1;
        wValid <= 1;
        while (!(awDone && wDone) && n < 100) begin
            @(posedge sys_clk);
            n++;
            if (awValid && awReady && !awDone) begin
                awDone = 1;
                awValid <= 0;
            end
            if (wValid && wReady && !wDone) begin
                wDone = 1;
                wValid <= 0;
            end
        end
        bReady <= 1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (bValid !== 1'b1 && n < 100);
        bReady <= 0;
        chk(bResp, expResp);
        if (n >= 100) numErrors++;
    endtask

    task automatic bus_read(input logic [17:0] a, input logic [31:0] expData, input logic [1:0] expResp);
        int n;
        n = 0;
        @(posedge sys_clk);
        arAddr <= a;
        arValid <= 1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (arReady !== 1'b1 && n < 100);
        arValid <= 0;
        rReady <= 1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (rValid !== 1'b1 && n < 100);
        rReady <= 0;
        chk(rData, expData);
        chk(rResp, expResp);
        if (n >= 100) numErrors++;
    endtask

    // outputs lag the register by a clock, so settle two edges first
    task automatic chk_amp(input logic en, input logic gr, input logic [1:0] ch, input logic [1:0] g);
        repeat (2) @(posedge sys_clk);
        #1;
        chk(ampEnable, en);
        chk(ampInputGround, gr);
        chk(ampChannelSel, gr ? 4'h0 : 4'h1 << ch);
        chk(ampGainFactor, 5'h02 << g);
        chk(ampGainOneHot, 4'h1 << g);
    endtask

    task automatic test_reset();
        #1;
        chk_amp(0, 0, 2'h0, 2'h0);
        bus_read(`AMP_PRI_ADDR, 32'h0000_0000, 2'h0);
        bus_read(`AMP_SEC_ADDR, 32'h0000_0000, 2'h0);
        chk(ampAuxControlBit, 1'b0);
    endtask

    // every gain code, enable held set
    task automatic test_gain();
        for (int g = 3; g >= 0; g--) begin
            bus_write(`AMP_PRI_ADDR, {24'h0, 6'h20, g[1:0]}, 4'h1, 2'h0);
            chk_amp(1, 0, 2'h0, g[1:0]);
            bus_read(`AMP_PRI_ADDR, {24'h0, 6'h20, g[1:0]}, 2'h0);
        end
    endtask

    // every channel with the input normal and grounded
    task automatic test_channel();
        for (int c = 0; c < 4; c++) begin
            for (int gr = 0; gr < 2; gr++) begin
                bus_write(`AMP_PRI_ADDR, {24'h0, 1'b0, c[1:0], gr[0], 4'h1}, 4'hf, 2'h0);
                chk_amp(0, gr[0], c[1:0], 2'h1);
            end
        end
    endtask

    // reserved bits read zero, strobe off stores nothing
    task automatic test_reserved();
        bus_write(`AMP_PRI_ADDR, 32'hffff_ffff, 4'hf, 2'h0);
        bus_read(`AMP_PRI_ADDR, 32'h0000_00f3, 2'h0);
        bus_write(`AMP_SEC_ADDR, 32'h0000_00ff, 4'h1, 2'h0);
        bus_read(`AMP_SEC_ADDR, 32'h0000_0001, 2'h0);
        chk_amp(1, 1, 2'h3, 2'h3);
        chk(ampAuxControlBit, 1'b1);
        bus_write(`AMP_SEC_ADDR, 32'h0000_0000, 4'he, 2'h0);
        bus_read(`AMP_SEC_ADDR, 32'h0000_0001, 2'h0);
        bus_write(`AMP_SEC_ADDR, 32'h0000_0000, 4'h1, 2'h0);
        #21;
        chk(ampAuxControlBit, 1'b0);
    endtask

    // unmapped places answer with an error and leave registers alone
    task automatic test_unmapped();
        bus_write(`AMP_PRI_ADDR, 32'h0000_00a2, 4'h1, 2'h0);
        bus_write(18'h3_ff88, 32'h0000_00ff, 4'h1, 2'h2);
        bus_write(18'h0_0000, 32'h0000_00ff, 4'h1, 2'h2);
        bus_read(18'h3_ff88, 32'h0000_0000, 2'h2);
        bus_read(`AMP_PRI_ADDR, 32'h0000_00a2, 2'h0);
        // a second reset in mid-run clears everything again
        @(posedge sys_clk);
        rst <= 1;
        repeat (3) @(posedge sys_clk);
        rst <= 0;
        test_reset();
    endtask

    task automatic stop_test();
        if (numErrors == 0 && nChecks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (8) @(posedge sys_clk);
        rst <= 0;
        test_reset();
        test_gain();
        test_channel();
        test_reserved();
        test_unmapped();
        stop_test();
    end

    // watchdog: whole run needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        numErrors++;
        stop_test();
    end
endmodule
